// file: include/dhm_map.svh
`ifndef DHM_MAP_SVH
`define DHM_MAP_SVH

// timing
`define DHM_CLK_PERIOD_NS    10
`define DHM_SD_TIME_NS       40000
`define DHM_SD_CYCLES        ((`DHM_SD_TIME_NS + `DHM_CLK_PERIOD_NS - 1) / `DHM_CLK_PERIOD_NS)
`define DHM_SD_W             12
`define DHM_OPEN_HOLD_MS     10
`define DHM_OPEN_HOLD_CYCLES ((`DHM_OPEN_HOLD_MS * 1000000) / `DHM_CLK_PERIOD_NS)
`define DHM_BLANK_CYCLES_DEF 1024
`define DHM_DEB_CYCLES_DEF   4

// register map
`define DHM_ADDR_W           4
`define DHM_CTRL_OFS         4'h0
`define DHM_STAT_OFS         4'h4
`define DHM_CTRL_RST         2'h3
`define DHM_RESP_OKAY        2'h0
`define DHM_RESP_SLVERR      2'h2

// diagnostic pair codes {sensor_output_1,sensor_output_2}
`define DHM_CODE_NONE        2'h0
`define DHM_CODE_OPEN        2'h1
`define DHM_CODE_BAT         2'h2
`define DHM_CODE_GND         2'h3

`endif

// file: include/dhm_pkg.sv
`default_nettype none
package dhm_pkg;

  // per-input channel state, gray along off-blank-run-open
  typedef enum logic [2:0] {
    S_OFF    = 3'h0,
    S_BLANK  = 3'h1,
    S_RUN    = 3'h3,
    S_OPEN   = 3'h2,
    S_GSHORT = 3'h6,
    S_BSHORT = 3'h7
  } dhm_ch_state_t;

  // comparator flags of one sensor input
  typedef struct packed {
    logic hi;
    logic lo;
    logic open;
    logic gshort;
    logic bshort;
  } dhm_cmp_t;

  // open-drain pin drive
  typedef struct packed {
    logic o;
    logic oe;
  } dhm_od_t;

  // status register layout
  typedef struct packed {
    logic [18:0]   zero;
    logic          fault_pin;
    logic          sensor_output_2_pin;
    logic          sensor_output_1_pin;
    logic          supply_ok;
    logic          shutdown;
    logic [1:0]    track;
    dhm_ch_state_t st2;
    dhm_ch_state_t st1;
  } dhm_stat_t;

endpackage
`default_nettype wire

// file: rtl/dhm_top.sv
// Design decisions made here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "dhm_map.svh"

// Overview of operation
// - current above high threshold drives output high
// - current below low threshold drives output low
// - normal mode, flag high: outputs track inputs
// - input 1 bad: flag low, output 1 low
// - input 2 bad: flag low, output 2 low
// - diagnostic select high gives encoded fault report
// - input 1 faults mask input 2 faults
// - flag low: pair encodes input 1 fault
// - flag high: supply/blanking, else input 2 fault
// - report follows live conditions, latched only for a ground short
// - with diagnostic select low, any input fault pulls fault flag low
// - supply out of range cuts both, restarts
// - open input cut, restarts when loaded again
// - battery short cuts that input only
// - ground short latches, only pull-up sourced
// - diagnostic select falling edge restarts ground-latched
// - long open on latched input gives open
// - other faults clear by themselves
// - ground short ignored while blanking
// - output enable low floats all outputs
// - both low 40us: shutdown until rising edge
module dhm_top #(
  parameter int unsigned BLANK_CYCLES     = `DHM_BLANK_CYCLES_DEF,
  parameter int unsigned DEB_CYCLES       = `DHM_DEB_CYCLES_DEF,
  parameter int unsigned OPEN_HOLD_CYCLES = `DHM_OPEN_HOLD_CYCLES
) (
  // clock, reset, enable
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   ce,
  // axi4-lite slave
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [`DHM_ADDR_W-1:0] awaddr,
  input  wire logic                   wvalid,
  output logic                        wready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  output logic                        bvalid,
  input  wire logic                   bready,
  output logic [1:0]                  bresp,
  input  wire logic                   arvalid,
  output logic                        arready,
  input  wire logic [`DHM_ADDR_W-1:0] araddr,
  output logic                        rvalid,
  input  wire logic                   rready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  // analog comparator flags
  input  wire logic                   supply_ok_cmp,
  input  wire dhm_pkg::dhm_cmp_t [1:0] sensor_input_cmp,
  // host control pins
  input  wire logic                   diagnostic_select,
  input  wire logic                   output_enable,
  // sensor input drive
  output logic [1:0]                  sensor_supply_en,
  output logic [1:0]                  sensor_pullup_en,
  // open-drain outputs
  input  wire logic                   sensor_output_1_i,
  input  wire logic                   sensor_output_2_i,
  input  wire logic                   fault_flag_n_i,
  output dhm_pkg::dhm_od_t            sensor_output_1,
  output dhm_pkg::dhm_od_t            sensor_output_2,
  output dhm_pkg::dhm_od_t            fault_flag_n
);
  import dhm_pkg::*;

  localparam int unsigned CNT_MAX = (BLANK_CYCLES > OPEN_HOLD_CYCLES) ? BLANK_CYCLES : OPEN_HOLD_CYCLES;
  localparam int          CNT_W   = $clog2(CNT_MAX + 1);
  localparam int          DEB_W   = $clog2(DEB_CYCLES + 1);
  localparam int          SD_W    = `DHM_SD_W;
  localparam int          NRAW    = 11;

  generate
    if (BLANK_CYCLES < 1 || DEB_CYCLES < 1 || OPEN_HOLD_CYCLES < 1) begin : g_bad
      $error("counts must be at least one");
    end
  endgenerate

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // comparator synchronizer and debounce
  logic [NRAW-1:0] raw;
  logic [NRAW-1:0] db;
  dhm_cmp_t [1:0]  cmp;
  logic            sup_ok;

  assign raw    = {supply_ok_cmp, sensor_input_cmp};
  assign cmp    = db[NRAW-2:0];
  assign sup_ok = db[NRAW-1];

  generate
    for (genvar b = 0; b < NRAW; b++) begin : g_deb
      logic             s1;
      logic             s2;
      logic             next_db;
      logic [DEB_W-1:0] dc;
      logic [DEB_W-1:0] next_dc;
      always_comb begin
        next_db = db[b];
        next_dc = dc;
        if (s2 == db[b]) begin
          next_dc = '0;
        end else if (dc == DEB_W'(DEB_CYCLES - 1)) begin
          next_db = s2;
          next_dc = '0;
        end else begin
          next_dc = dc + 1'b1;
        end
      end
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          s1    <= 1'b0;
          s2    <= 1'b0;
          db[b] <= 1'b0;
          dc    <= '0;
        end else if (ce) begin
          s1    <= raw[b];
          s2    <= s1;
          db[b] <= next_db;
          dc    <= next_dc;
        end
      end
    end
  endgenerate

  // host pin history and shutdown
  logic            diagnostic_select_q;
  logic            oe_q;
  logic            sd;
  logic            next_sd;
  logic [SD_W-1:0] sd_cnt;
  logic [SD_W-1:0] next_sd_cnt;
  logic            diagnostic_select_fall;
  localparam logic [SD_W-1:0] SD_LAST = SD_W'(`DHM_SD_CYCLES);

  assign diagnostic_select_fall = diagnostic_select_q && !diagnostic_select;

  always_comb begin
    next_sd     = sd;
    next_sd_cnt = sd_cnt;
    if (sd) begin
      next_sd_cnt = '0;
      if ((diagnostic_select && !diagnostic_select_q) || (output_enable && !oe_q)) begin
        next_sd = 1'b0;
      end
    end else if (!output_enable && !diagnostic_select) begin
      if (sd_cnt == SD_LAST) begin
        next_sd = 1'b1;
      end else begin
        next_sd_cnt = sd_cnt + 1'b1;
      end
    end else begin
      next_sd_cnt = '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      diagnostic_select_q <= 1'b0;
      oe_q   <= 1'b0;
      sd     <= 1'b0;
      sd_cnt <= '0;
    end else if (ce) begin
      diagnostic_select_q <= diagnostic_select;
      oe_q   <= output_enable;
      sd     <= next_sd;
      sd_cnt <= next_sd_cnt;
    end
  end

  sequence s_diagnostic_select_fall;
    ce && diagnostic_select_fall;
  endsequence

  // per-input fault state machine
  logic [1:0]    ch_en;
  logic [1:0]    trk;
  dhm_ch_state_t st [2];

  generate
    for (genvar i = 0; i < 2; i++) begin : g_ch
      dhm_ch_state_t    cs;
      dhm_ch_state_t    next_cs;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] next_cnt;
      logic             t;
      logic             next_t;

      assign st[i]               = cs;
      assign trk[i]              = t;
      assign sensor_supply_en[i] = (cs == S_RUN) || (cs == S_BLANK);
      assign sensor_pullup_en[i] = (cs == S_GSHORT);

      always_comb begin
        next_cs  = cs;
        next_cnt = cnt;
        next_t   = t;
        if (cmp[i].hi) begin
          next_t = 1'b1;
        end else if (cmp[i].lo) begin
          next_t = 1'b0;
        end
        if (!sup_ok || !ch_en[i]) begin
          next_cs = S_OFF;
        end else begin
          unique case (cs)
            S_OFF: begin
              next_cs  = S_BLANK;
              next_cnt = CNT_W'(BLANK_CYCLES - 1);
            end
            S_BLANK: begin // ground short ignored here
              if (cnt == '0) begin
                next_cs = S_RUN;
              end else begin
                next_cnt = cnt - 1'b1;
              end
            end
            S_RUN: begin
              next_cnt = '0;
              if (cmp[i].open) begin
                next_cs = S_OPEN;
              end else if (cmp[i].bshort) begin
                next_cs = S_BSHORT;
              end else if (cmp[i].gshort) begin
                next_cs = S_GSHORT;
              end
            end
            S_OPEN, S_BSHORT: begin
              if ((cs == S_OPEN) ? !cmp[i].open : !cmp[i].bshort) begin
                next_cs  = S_BLANK;
                next_cnt = CNT_W'(BLANK_CYCLES - 1);
              end
            end
            S_GSHORT: begin
              if (diagnostic_select_fall) begin
                next_cs  = S_BLANK;
                next_cnt = CNT_W'(BLANK_CYCLES - 1);
              end else if (!cmp[i].open) begin
                next_cnt = '0;
              end else if (cnt == CNT_W'(OPEN_HOLD_CYCLES - 1)) begin
                next_cs  = S_OPEN;
                next_cnt = '0;
              end else begin
                next_cnt = cnt + 1'b1;
              end
            end
            default: next_cs = S_OFF;
          endcase
        end
      end

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cs  <= S_OFF;
          cnt <= '0;
          t   <= 1'b0;
        end else if (ce) begin
          cs  <= next_cs;
          cnt <= next_cnt;
          t   <= next_t;
        end
      end

      a_blank_no_gnd: assert property (ce && cs == S_BLANK |=> cs != S_GSHORT)
        else $error("ground short taken during blanking");
      a_open_cut: assert property (cs == S_OPEN || cs == S_BSHORT |-> !sensor_supply_en[i])
        else $error("faulted input still supplied");
      a_gnd_pullup: assert property (cs == S_GSHORT |-> sensor_pullup_en[i] && !sensor_supply_en[i])
        else $error("ground latch drive wrong");
      a_diagnostic_select_restart: assert property (s_diagnostic_select_fall ##0 (cs == S_GSHORT && sup_ok && ch_en[i])
                                        |=> cs == S_BLANK)
        else $error("falling select did not restart");
      a_track_high: assert property (ce && cmp[i].hi |=> t)
        else $error("tracked state not high");
    end
  endgenerate

  // pin encoding
  function automatic logic [1:0] fcode(input dhm_ch_state_t s);
    logic [1:0] c;
    c = `DHM_CODE_NONE;
    if (s == S_OPEN) c = `DHM_CODE_OPEN;
    if (s == S_BSHORT) c = `DHM_CODE_BAT;
    if (s == S_GSHORT) c = `DHM_CODE_GND;
    return c;
  endfunction

  logic    [1:0] bad;
  logic    [1:0] flt;
  logic          err_v;
  logic    [1:0] pair;
  dhm_od_t       next_o1;
  dhm_od_t       next_o2;
  dhm_od_t       next_err;
  logic          drv;

  always_comb begin
    bad  = {st[1] != S_RUN, st[0] != S_RUN};
    flt  = {fcode(st[1]) != `DHM_CODE_NONE, fcode(st[0]) != `DHM_CODE_NONE};
    drv  = output_enable && !sd;
    if (!diagnostic_select) begin
      err_v = !(bad[0] || bad[1]);
      pair  = {!bad[0] && trk[0], !bad[1] && trk[1]};
    end else if (flt[0]) begin
      err_v = 1'b0;
      pair  = fcode(st[0]);
    end else if (bad[0] || st[1] == S_BLANK || st[1] == S_OFF) begin
      err_v = 1'b1;
      pair  = `DHM_CODE_NONE;
    end else begin
      err_v = flt[1];
      pair  = fcode(st[1]);
    end
    next_o1  = '{o: 1'b0, oe: drv && !pair[1]};
    next_o2  = '{o: 1'b0, oe: drv && !pair[0]};
    next_err = '{o: 1'b0, oe: drv && !err_v};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sensor_output_1 <= '0;
      sensor_output_2 <= '0;
      fault_flag_n    <= '0;
    end else if (ce) begin
      sensor_output_1 <= next_o1;
      sensor_output_2 <= next_o2;
      fault_flag_n    <= next_err;
    end
  end

  // axi4-lite register slave
  logic                   aw_held;
  logic                   w_held;
  logic [`DHM_ADDR_W-1:0] aw_q;
  logic [31:0]            wd_q;
  logic                   ws_q;
  logic                   next_aw_held;
  logic                   next_w_held;
  logic                   next_bvalid;
  logic [1:0]             next_bresp;
  logic [1:0]             next_ch_en;
  logic                   next_rvalid;
  logic [31:0]            next_rdata;
  logic [1:0]             next_rresp;
  dhm_stat_t              stat;

  assign awready = ce && !aw_held;
  assign wready  = ce && !w_held;
  assign arready = ce && !rvalid;

  always_comb begin
    stat = '{zero: '0, fault_pin: fault_flag_n_i, sensor_output_2_pin: sensor_output_2_i,
             sensor_output_1_pin: sensor_output_1_i, supply_ok: sup_ok, shutdown: sd,
             track: trk, st2: st[1], st1: st[0]};
    next_aw_held = aw_held || (awvalid && awready);
    next_w_held  = w_held || (wvalid && wready);
    next_bvalid  = bvalid && !bready;
    next_bresp   = bresp;
    next_ch_en   = ch_en;
    if (aw_held && w_held && !bvalid) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = `DHM_RESP_OKAY;
      if ({aw_q[`DHM_ADDR_W-1:2], 2'b00} == `DHM_CTRL_OFS) begin
        if (ws_q) next_ch_en = wd_q[1:0];
      end else if ({aw_q[`DHM_ADDR_W-1:2], 2'b00} != `DHM_STAT_OFS) begin
        next_bresp = `DHM_RESP_SLVERR;
      end
    end
    next_rvalid = rvalid && !rready;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp  = `DHM_RESP_OKAY;
      next_rdata  = '0;
      if ({araddr[`DHM_ADDR_W-1:2], 2'b00} == `DHM_CTRL_OFS) begin
        next_rdata = {30'h0, ch_en};
      end else if ({araddr[`DHM_ADDR_W-1:2], 2'b00} == `DHM_STAT_OFS) begin
        next_rdata = stat;
      end else begin
        next_rresp = `DHM_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_q    <= '0;
      wd_q    <= '0;
      ws_q    <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= `DHM_RESP_OKAY;
      ch_en   <= `DHM_CTRL_RST;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= `DHM_RESP_OKAY;
    end else if (ce) begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      if (awvalid && awready) aw_q <= awaddr;
      if (wvalid && wready) wd_q <= wdata;
      if (wvalid && wready) ws_q <= wstrb[0];
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      ch_en   <= next_ch_en;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
    end
  end

  // pin-level checks
  sequence s_norm_run;
    ce && !diagnostic_select && output_enable && !sd && st[0] == S_RUN && st[1] == S_RUN;
  endsequence

  sequence s_in1_open;
    ce && diagnostic_select && output_enable && !sd && st[0] == S_OPEN;
  endsequence

  a_supply_cut: assert property (ce && !sup_ok |=> st[0] == S_OFF && st[1] == S_OFF)
    else $error("supply loss did not cut both inputs");
  a_oe_float: assert property (ce && !output_enable
                               |=> !fault_flag_n.oe && !sensor_output_1.oe && !sensor_output_2.oe)
    else $error("outputs driven with enable low");
  a_sd_enter: assert property (ce && !sd && sd_cnt == SD_LAST && !output_enable && !diagnostic_select
                               |=> sd ##0 (!fault_flag_n.oe && !sensor_output_1.oe))
    else $error("shutdown not entered");
  a_norm_track: assert property (s_norm_run |=> !fault_flag_n.oe && sensor_output_1.oe == !$past(trk[0]))
    else $error("normal output does not track input");
  a_norm_both: assert property (ce && !diagnostic_select && output_enable && !sd && st[0] != S_RUN && st[1] != S_RUN
                                |=> fault_flag_n.oe && sensor_output_1.oe && sensor_output_2.oe)
    else $error("supply loss not reported low");
  a_diagnostic_select_open1: assert property (s_in1_open |=> fault_flag_n.oe && sensor_output_1.oe && !sensor_output_2.oe)
    else $error("input 1 open code wrong");

endmodule
`default_nettype wire

// file: verif/dhm_host.sv
`timescale 1ns/1ps
`default_nettype none
module dhm_host (
  // open-drain drives from the device
  input  wire dhm_pkg::dhm_od_t sensor_output_1_od,
  input  wire dhm_pkg::dhm_od_t sensor_output_2_od,
  input  wire dhm_pkg::dhm_od_t flag_od,
  // pin levels seen by the host
  output logic                  sensor_output_1_lvl,
  output logic                  sensor_output_2_lvl,
  output logic                  flag_lvl
);
  import dhm_pkg::*;
  // host-side pull-ups win wherever the device lets go
  assign sensor_output_1_lvl = sensor_output_1_od.oe ? sensor_output_1_od.o : 1'b1;
  assign sensor_output_2_lvl = sensor_output_2_od.oe ? sensor_output_2_od.o : 1'b1;
  assign flag_lvl = flag_od.oe ? flag_od.o : 1'b1;
endmodule
`default_nettype wire

// file: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "dhm_map.svh"
module tb;
  import dhm_pkg::*;
  logic            aclk = 1'b0;
  logic            aresetn = 1'b0;
  logic            ce = 1'b1;
  logic            awvalid = 1'b0;
  logic            wvalid = 1'b0;
  logic            bready = 1'b0;
  logic            arvalid = 1'b0;
  logic            rready = 1'b0;
  logic [3:0]      awaddr = 4'h0;
  logic [3:0]      araddr = 4'h0;
  logic [31:0]     wdata = 32'h0;
  logic            awready, wready, bvalid, arready, rvalid;
  logic [1:0]      bresp, rresp, rs, sup_en, pu_en;
  logic [31:0]     rdata, rd;
  logic            supply_ok = 1'b1;
  logic            diagnostic_select_sel = 1'b0;
  logic            out_en = 1'b1;
  dhm_cmp_t [1:0]  cmp = {2{5'h10}};
  dhm_od_t         od1, od2, odf;
  logic            p1, p2, pf, seen;
  int              miscompares = 0;
  int              n_compared = 0;
  int              fb[3] = '{2, 0, 1};

  always #5 aclk = ~aclk;

  dhm_top #(.BLANK_CYCLES(8), .DEB_CYCLES(1), .OPEN_HOLD_CYCLES(8)) dhm_top_i (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .supply_ok_cmp(supply_ok), .sensor_input_cmp(cmp),
    .diagnostic_select(diagnostic_select_sel), .output_enable(out_en),
    .sensor_supply_en(sup_en), .sensor_pullup_en(pu_en),
    .sensor_output_1_i(p1), .sensor_output_2_i(p2), .fault_flag_n_i(pf),
    .sensor_output_1(od1), .sensor_output_2(od2), .fault_flag_n(odf));

  dhm_host dhm_host_i (.sensor_output_1_od(od1), .sensor_output_2_od(od2), .flag_od(odf),
    .sensor_output_1_lvl(p1), .sensor_output_2_lvl(p2), .flag_lvl(pf));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // pins are sampled mid-cycle; returns just after a rising edge
  task pins(input logic [2:0] exp);
    @(negedge aclk);
    chk({29'h0, pf, p1, p2}, {29'h0, exp});
    @(posedge aclk);
  endtask

  task settle(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task axw(input logic [3:0] a, input logic [31:0] d);
    logic [1:0] pend;
    int         n;
    pend = 2'b11;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (n < 200) begin
      @(negedge aclk);
      n++;
      if (bvalid && pend == 2'b00) begin
        rs = bresp;
        n = 999;
      end
      if (awready) pend[0] = 1'b0;
      if (wready) pend[1] = 1'b0;
      @(posedge aclk);
      awvalid <= pend[0];
      wvalid <= pend[1];
      if (n == 999) bready <= 1'b0;
    end
    if (n < 999) miscompares++;
    // idle edge so a following call never reassigns a strobe in the same step
    @(posedge aclk);
  endtask

  task axr(input logic [3:0] a);
    logic pend;
    int   n;
    pend = 1'b1;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (n < 200) begin
      @(negedge aclk);
      n++;
      if (rvalid) begin
        rd = rdata;
        rs = rresp;
        n = 999;
      end
      if (arready) pend = 1'b0;
      @(posedge aclk);
      arvalid <= pend;
      if (n == 999) rready <= 1'b0;
    end
    if (n < 999) miscompares++;
    // idle edge so a following call never reassigns a strobe in the same step
    @(posedge aclk);
  endtask

  task t_regs;
    axr(`DHM_CTRL_OFS);
    chk(rd, 32'h3);
    axr(4'h8);
    chk({30'h0, rs}, 32'h2);
    chk(rd, 32'h0);
    axw(`DHM_STAT_OFS, 32'h0);
    chk({30'h0, rs}, 32'h0);
    axw(4'hC, 32'h0);
    chk({30'h0, rs}, 32'h2);
    axr(`DHM_STAT_OFS);
    chk(rd, 32'h1EDB);
  endtask

  task t_track;
    cmp[0] <= 5'h08;
    settle(10);
    pins(3'b101);
    cmp[0] <= 5'h10;
    settle(10);
    pins(3'b111);
    axw(`DHM_CTRL_OFS, 32'h1);
    settle(10);
    pins(3'b010);
    cmp[1].gshort <= 1'b1;
    axw(`DHM_CTRL_OFS, 32'h3);
    // load-charging pulse that falls wholly inside the restart blanking
    cmp[1].gshort <= 1'b0;
    settle(30);
    pins(3'b111);
  endtask

  // each fault kind on each input, normal then diagnostic view
  task t_faults;
    for (int ch = 0; ch < 2; ch++) begin
      for (int f = 0; f < 3; f++) begin
        cmp[ch][fb[f]] <= 1'b1;
        settle(12);
        pins(ch == 0 ? 3'b001 : 3'b010);
        chk({30'h0, sup_en}, 32'(2'b11 ^ 2'(1 << ch)));
        chk({30'h0, pu_en}, f == 2 ? 32'(1 << ch) : 32'h0);
        diagnostic_select_sel <= 1'b1;
        settle(4);
        pins({ch[0], 2'(f + 1)});
        cmp[ch][fb[f]] <= 1'b0;
        settle(20);
        pins(f == 2 ? {ch[0], 2'b11} : 3'b000);
        diagnostic_select_sel <= 1'b0;
        settle(20);
        pins(3'b111);
      end
    end
  endtask

  // latched ground short left through an open input
  task t_reconnect;
    cmp[0].gshort <= 1'b1;
    settle(12);
    cmp[0].gshort <= 1'b0;
    diagnostic_select_sel <= 1'b1;
    cmp[0].open <= 1'b1;
    settle(20);
    pins(3'b001);
    cmp[0].open <= 1'b0;
    seen = 1'b0;
    repeat (30) begin
      @(negedge aclk);
      if ({pf, p1, p2} === 3'b100) seen = 1'b1;
    end
    @(posedge aclk);
    chk({31'h0, seen}, 32'h1);
    pins(3'b000);
    diagnostic_select_sel <= 1'b0;
    settle(20);
    pins(3'b111);
  endtask

  task t_supply;
    supply_ok <= 1'b0;
    settle(10);
    pins(3'b000);
    chk({30'h0, sup_en}, 32'h0);
    diagnostic_select_sel <= 1'b1;
    settle(4);
    pins(3'b100);
    out_en <= 1'b0;
    settle(4);
    pins(3'b111);
    diagnostic_select_sel <= 1'b0;
    supply_ok <= 1'b1;
    settle(4010);
    axr(`DHM_STAT_OFS);
    chk({31'h0, rd[8]}, 32'h1);
    out_en <= 1'b1;
    settle(4);
    axr(`DHM_STAT_OFS);
    chk({31'h0, rd[8]}, 32'h0);
    pins(3'b111);
  endtask

  task end_of_test;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    settle(2);
    aresetn <= 1'b1;
    settle(30);
    t_regs;
    t_track;
    t_faults;
    t_reconnect;
    t_supply;
    end_of_test;
  end

  initial begin
    settle(20000);
    miscompares++;
    end_of_test;
  end
endmodule
`default_nettype wire
